// ### inc/lidi_pkg.sv
// Constants for the line IO debounce and interrupt collection block.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
//
// Notes on behaviour
// R1 - Four IO pins per channel, own direction bit
// R2 - Input pin shows debounced state in value field
// R3 - Output pin drives last written value bit
// R4 - External ringing forces first IO pin output
// R5 - Filter flips only after full opposite-level hold
// R6 - Period 0..30 ms, 2 ms steps, plus 2.5 ms
// R7 - Debounce period field resets to zero
// R8 - Input IO change interrupts unless its mask set
// R9 - Global hook/ground-key bits, local bits for others
// R10 - Status bit set while pending, held until cleared
// R11 - Mask suppresses; tone and level always interrupt
// R12 - Hook, ground-key, polarity interrupt on any change
// R13 - Temperature, ramp, tone, level interrupt on rise
// R14 - Parallel-port mode drives interrupt pin when pending
// R15 - Serial mode sets affected channel's upstream flag
// R16 - Polarity bit: 0 active low, 1 active high
// R17 - Reading a status register clears its pending bits
// R18 - Global status write clears all status registers
// R19 - Hardware reset clears status, outputs go inactive
// R20 - Software reset clears only that channel's local status
// R21 - Host selects clock before programming other parameters
// R22 - Interrupt output inactive once nothing unmasked pending
package lidi_pkg;

  // ****************************************************
  // Sizes
  // ****************************************************
  localparam int NUM_CH = 4; // Channels
  localparam int IO_PER_CH = 4; // IO pins per channel
  localparam int NUM_IO = NUM_CH * IO_PER_CH; // All IO pins
  localparam int DB_CNT_W = 7; // Debounce counter width

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_PERIOD_NS = 100; // 10 MHz clock
  localparam int TICK_PERIOD_US = 500; // Debounce time base
  localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS; // Cycles per tick
  localparam int DB_FIXED_US = 2500; // Fixed filter delay
  localparam int DB_STEP_US = 2000; // Period step size
  localparam int DB_FIXED_TICKS = DB_FIXED_US / TICK_PERIOD_US; // Fixed delay in ticks
  localparam int DB_STEP_TICKS = DB_STEP_US / TICK_PERIOD_US; // Step in ticks

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [3:0] DB_PERIOD_RST = 4'h0; // Shortest debounce
  localparam logic [IO_PER_CH-1:0] IO_DIR_RST = 4'h0; // All pins inputs
  localparam logic [IO_PER_CH-1:0] IO_MASK_RST = 4'hf; // All IO masked
  localparam logic MASK_RST = 1'b1; // Maskable sources masked

  // ****************************************************
  // Local event status bit positions
  // ****************************************************
  localparam int EV_GKP = 0; // Ground-key polarity change
  localparam int EV_OVER_TEMPERATURE_FLAG = 1; // Over temperature rise
  localparam int EV_RAMP = 2; // Ramp done rise
  localparam int EV_TONE = 3; // Tone detect done rise
  localparam int EV_LEVEL = 4; // Level meter done rise
  localparam int EV_W = 5; // Event bits per channel

endpackage

// ### rtl/lidi_tick.sv
// Divider making the debounce time base enable pulse.
// Assumes clock_i is the only clock; tick_o lasts one cycle.
`timescale 1ns/1ps
module lidi_tick
  import lidi_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES
)
(
  input wire logic clock_i, // System clock
  input wire logic reset_i, // Synchronous reset
  output logic tick_o // One-cycle enable
);

  logic [15:0] cnt_ff; // Cycle counter

  // ****************************************************
  // Count up, pulse at wrap
  // ****************************************************
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      cnt_ff <= 16'h0000;
      tick_o <= 1'b0;
    end
    else if (cnt_ff == 16'(CYCLES - 1))
    begin
      cnt_ff <= 16'h0000; // Wrap
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule

// ### rtl/lidi_debounce.sv
// Debounce filter for one IO input.
// Assumes pin_i is synchronous and tick_i is a one-cycle time base.
`timescale 1ns/1ps
module lidi_debounce
  import lidi_pkg::*;
(
  input wire logic clock_i, // System clock
  input wire logic reset_i, // Synchronous reset
  input wire logic tick_i, // Time base enable
  input wire logic [DB_CNT_W-1:0] target_i, // Hold length in ticks
  input wire logic pin_i, // Raw pin level
  output logic level_o // Filtered level
);

  logic [DB_CNT_W-1:0] cnt_ff; // Ticks spent at opposite level

  // ****************************************************
  // Count opposite-level time, flip when full
  // ****************************************************
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      cnt_ff <= '0;
      level_o <= 1'b0;
    end
    else if (pin_i == level_o)
      cnt_ff <= '0; // Any return restarts the hold, see R5
    else if (tick_i)
    begin
      if (cnt_ff >= target_i)
      begin
        level_o <= pin_i; // Held for the whole period, see R5
        cnt_ff <= '0;
      end
      else
        cnt_ff <= cnt_ff + DB_CNT_W'(1);
    end
  end

  a_db_full_hold: assert property (@(posedge clock_i) disable iff (reset_i) // see R5
    $changed(level_o) |-> $past(tick_i) && ($past(cnt_ff) >= $past(target_i)))
    else $error("Filter flipped before hold period elapsed");

endmodule

// ### rtl/lidi_top.sv
// Line IO pins with debounce and chip-wide interrupt collection.
// Assumes synchronous pins, one 10 MHz clock, host reads given as pulses.
`timescale 1ns/1ps
module lidi_top
  import lidi_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES // Cycles per debounce tick
)
(
  input wire logic clock_i, // System clock
  input wire logic reset_i, // Hardware or power-on reset
  input wire logic [NUM_CH-1:0] sw_reset_i, // Per-channel software reset pulse
  input wire logic host_port_mode_i, // 1 parallel port, 0 serial channel
  input wire logic irq_polarity_i, // 1 active high, 0 active low
  input wire logic [NUM_IO-1:0] io_dir_i, // 1 output, 0 input
  input wire logic [NUM_IO-1:0] io_wr_value_i, // Value for output pins
  input wire logic [4*NUM_CH-1:0] io_debounce_period_i, // 4 bits per channel
  input wire logic [NUM_CH-1:0] ext_ring_i, // External ringing selected
  input wire logic [NUM_IO-1:0] io_pin_i, // Pin input level
  output logic [NUM_IO-1:0] io_pin_o, // Pin output level
  output logic [NUM_IO-1:0] io_oe_o, // Pin driven
  output logic [NUM_IO-1:0] io_value_o, // IO value field
  input wire logic [NUM_CH-1:0] hook_state_i, // Hook or ring-trip result
  input wire logic [NUM_CH-1:0] ground_key_state_i, // Ground-key result
  input wire logic [NUM_CH-1:0] ground_key_polarity_i, // Ground-key polarity
  input wire logic [NUM_CH-1:0] over_temperature_flag_i, // Over temperature
  input wire logic [NUM_CH-1:0] ramp_done_i, // Ramp finished
  input wire logic [NUM_CH-1:0] tone_detect_done_flag_i, // Tone detector done
  input wire logic [NUM_CH-1:0] level_meter_done_flag_i, // Level meter done
  input wire logic [NUM_CH-1:0] hook_mask_i, // Mask hook source
  input wire logic [NUM_CH-1:0] ground_key_mask_i, // Mask ground-key
  input wire logic [NUM_CH-1:0] ground_key_polarity_mask_i, // Mask polarity
  input wire logic [NUM_CH-1:0] over_temperature_mask_i, // Mask temperature
  input wire logic [NUM_CH-1:0] ramp_mask_i, // Mask ramp
  input wire logic [NUM_IO-1:0] io_mask_i, // Mask per IO bit
  input wire logic global_status_rd_i, // Read of global status
  input wire logic global_status_wr_i, // Write of global status
  input wire logic [NUM_CH-1:0] io_status_rd_i, // Read of local IO status
  input wire logic [NUM_CH-1:0] event_status_rd_i, // Read of local event status
  output logic [2*NUM_CH-1:0] global_irq_status_o, // {ground-key, hook} pending
  output logic [NUM_IO-1:0] local_io_status_o, // IO change pending
  output logic [EV_W*NUM_CH-1:0] local_event_status_o, // Event pending
  output logic irq_o, // Interrupt pin
  output logic [1:0] upstream_irq_first_o, // Flags of channels 0 and 2
  output logic [1:0] upstream_irq_second_o // Flags of channels 1 and 3
);

  // ****************************************************
  // Declarations
  // ****************************************************
  logic tick; // Debounce time base
  logic [NUM_IO-1:0] dir_ff; // Captured direction
  logic [NUM_IO-1:0] io_mask_ff; // Captured IO masks
  logic [4*NUM_CH-1:0] db_period_ff; // Captured debounce periods
  logic [NUM_CH-1:0] src_mask_ff [5]; // Hook, ground-key, polarity, temp, ramp masks
  logic [NUM_IO-1:0] force_out; // Pins forced to output
  logic [NUM_IO-1:0] db_level; // Filtered pin levels
  logic [NUM_IO-1:0] db_level_ff; // Previous filtered levels
  logic [NUM_CH-1:0] hook_ff; // Previous hook state
  logic [NUM_CH-1:0] gk_ff; // Previous ground-key state
  logic [NUM_CH-1:0] gkp_ff; // Previous polarity
  logic [NUM_CH-1:0] over_temperature_flag_ff; // Previous temperature flag
  logic [NUM_CH-1:0] ramp_ff; // Previous ramp flag
  logic [NUM_CH-1:0] tone_ff; // Previous tone flag
  logic [NUM_CH-1:0] level_ff; // Previous level meter flag
  logic [NUM_CH-1:0] hook_set; // Hook change events
  logic [NUM_CH-1:0] gk_set; // Ground-key change events
  logic [NUM_IO-1:0] io_set; // IO change events
  logic [EV_W*NUM_CH-1:0] ev_set; // Local event sets
  logic [NUM_CH-1:0] chan_irq; // Unmasked pending per channel
  logic any_irq; // Anything unmasked pending

  // ****************************************************
  // Time base
  // ****************************************************
  lidi_tick #(
    .CYCLES(TICK_LEN)
  ) u_tick (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .tick_o(tick)
  );

  // ****************************************************
  // Configuration capture with reset values
  // ****************************************************
  // Per channel: software reset returns pins to inputs and masks set
  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_cfg
      always_ff @(posedge clock_i)
      begin
        if (reset_i || sw_reset_i[c])
        begin
          dir_ff[IO_PER_CH*c +: IO_PER_CH] <= IO_DIR_RST;
          io_mask_ff[IO_PER_CH*c +: IO_PER_CH] <= IO_MASK_RST;
          db_period_ff[4*c +: 4] <= DB_PERIOD_RST; // see R7
          src_mask_ff[0][c] <= MASK_RST;
          src_mask_ff[1][c] <= MASK_RST;
          src_mask_ff[2][c] <= MASK_RST;
          src_mask_ff[3][c] <= MASK_RST;
          src_mask_ff[4][c] <= MASK_RST;
        end
        else
        begin
          dir_ff[IO_PER_CH*c +: IO_PER_CH] <= io_dir_i[IO_PER_CH*c +: IO_PER_CH]; // see R1
          io_mask_ff[IO_PER_CH*c +: IO_PER_CH] <= io_mask_i[IO_PER_CH*c +: IO_PER_CH];
          db_period_ff[4*c +: 4] <= io_debounce_period_i[4*c +: 4];
          src_mask_ff[0][c] <= hook_mask_i[c];
          src_mask_ff[1][c] <= ground_key_mask_i[c];
          src_mask_ff[2][c] <= ground_key_polarity_mask_i[c];
          src_mask_ff[3][c] <= over_temperature_mask_i[c];
          src_mask_ff[4][c] <= ramp_mask_i[c];
        end
      end
    end
  endgenerate

  // ****************************************************
  // Per-pin debounce, drive and interrupt source
  // ****************************************************
  genvar p;
  generate
    for (p = 0; p < NUM_IO; p++)
    begin : g_pin
      localparam int CH = p / IO_PER_CH; // Owning channel
      logic [DB_CNT_W-1:0] target; // Hold length in ticks

      // First relay pin of a channel follows external ringing
      assign force_out[p] = ((p % IO_PER_CH) == 0) ? ext_ring_i[CH] : 1'b0; // see R4

      // Fixed delay plus programmed steps
      assign target = DB_CNT_W'(DB_FIXED_TICKS) +
                      DB_CNT_W'(DB_STEP_TICKS * int'(db_period_ff[4*CH +: 4])); // see R6

      lidi_debounce u_db (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .tick_i(tick),
        .target_i(target),
        .pin_i(io_pin_i[p]),
        .level_o(db_level[p])
      );

      // Change of the filtered bit on an input pin
      assign io_set[p] = (db_level[p] != db_level_ff[p]) && !dir_ff[p] && !force_out[p]; // see R8
    end
  endgenerate

  // ****************************************************
  // Pin outputs and value field
  // ****************************************************
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      io_oe_o <= '0;
      io_pin_o <= '0;
      io_value_o <= '0;
    end
    else
    begin
      io_oe_o <= dir_ff | force_out; // see R1 R4
      io_pin_o <= force_out | (io_wr_value_i & ~force_out); // see R3 R4
      io_value_o <= (dir_ff & io_wr_value_i) | (~dir_ff & db_level); // see R2 R3
    end
  end

  // ****************************************************
  // Previous source levels for change detection
  // ****************************************************
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      db_level_ff <= '0;
      hook_ff <= '0;
      gk_ff <= '0;
      gkp_ff <= '0;
      over_temperature_flag_ff <= '0;
      ramp_ff <= '0;
      tone_ff <= '0;
      level_ff <= '0;
    end
    else
    begin
      db_level_ff <= db_level;
      hook_ff <= hook_state_i;
      gk_ff <= ground_key_state_i;
      gkp_ff <= ground_key_polarity_i;
      over_temperature_flag_ff <= over_temperature_flag_i;
      ramp_ff <= ramp_done_i;
      tone_ff <= tone_detect_done_flag_i;
      level_ff <= level_meter_done_flag_i;
    end
  end

  // Both-direction sources
  assign hook_set = hook_ff ^ hook_state_i; // see R12
  assign gk_set = gk_ff ^ ground_key_state_i; // see R12

  // Local event sets per channel
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_ev
      assign ev_set[EV_W*c+EV_GKP] = gkp_ff[c] ^ ground_key_polarity_i[c]; // see R12
      assign ev_set[EV_W*c+EV_OVER_TEMPERATURE_FLAG] = !over_temperature_flag_ff[c] && over_temperature_flag_i[c]; // see R13
      assign ev_set[EV_W*c+EV_RAMP] = !ramp_ff[c] && ramp_done_i[c]; // see R13
      assign ev_set[EV_W*c+EV_TONE] = !tone_ff[c] && tone_detect_done_flag_i[c]; // see R13
      assign ev_set[EV_W*c+EV_LEVEL] = !level_ff[c] && level_meter_done_flag_i[c]; // see R13
    end
  endgenerate

  // ****************************************************
  // Global status: hook and ground-key per channel
  // ****************************************************
  // Set wins over read or write clear in the same cycle
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      global_irq_status_o <= '0; // see R19
    else if (global_status_rd_i || global_status_wr_i)
      global_irq_status_o <= {gk_set, hook_set}; // see R17 R18
    else
      global_irq_status_o <= global_irq_status_o | {gk_set, hook_set}; // see R9 R10
  end

  // ****************************************************
  // Local status per channel
  // ****************************************************
  generate
    for (c = 0; c < NUM_CH; c++)
    begin : g_loc
      // IO change pending bits
      always_ff @(posedge clock_i)
      begin
        if (reset_i)
          local_io_status_o[IO_PER_CH*c +: IO_PER_CH] <= '0; // see R19
        else if (sw_reset_i[c] || io_status_rd_i[c] || global_status_wr_i)
          local_io_status_o[IO_PER_CH*c +: IO_PER_CH] <= io_set[IO_PER_CH*c +: IO_PER_CH]; // see R17 R18 R20
        else
          local_io_status_o[IO_PER_CH*c +: IO_PER_CH] <=
            local_io_status_o[IO_PER_CH*c +: IO_PER_CH] | io_set[IO_PER_CH*c +: IO_PER_CH]; // see R10
      end

      // Event pending bits
      always_ff @(posedge clock_i)
      begin
        if (reset_i)
          local_event_status_o[EV_W*c +: EV_W] <= '0; // see R19
        else if (sw_reset_i[c] || event_status_rd_i[c] || global_status_wr_i)
          local_event_status_o[EV_W*c +: EV_W] <= ev_set[EV_W*c +: EV_W]; // see R17 R18 R20
        else
          local_event_status_o[EV_W*c +: EV_W] <=
            local_event_status_o[EV_W*c +: EV_W] | ev_set[EV_W*c +: EV_W]; // see R9 R10
      end

      // Unmasked pending for this channel; tone and level have no mask
      assign chan_irq[c] =
        (global_irq_status_o[c] && !src_mask_ff[0][c]) ||
        (global_irq_status_o[NUM_CH+c] && !src_mask_ff[1][c]) ||
        (local_event_status_o[EV_W*c+EV_GKP] && !src_mask_ff[2][c]) ||
        (local_event_status_o[EV_W*c+EV_OVER_TEMPERATURE_FLAG] && !src_mask_ff[3][c]) ||
        (local_event_status_o[EV_W*c+EV_RAMP] && !src_mask_ff[4][c]) ||
        local_event_status_o[EV_W*c+EV_TONE] ||
        local_event_status_o[EV_W*c+EV_LEVEL] ||
        (|(local_io_status_o[IO_PER_CH*c +: IO_PER_CH] & ~io_mask_ff[IO_PER_CH*c +: IO_PER_CH])); // see R8 R11

      // Pin behaviour checks for the first two pins of this channel, then software reset scope
      a_ring_force: assert property (@(posedge clock_i) disable iff (reset_i) // see R4
        ext_ring_i[c] |=> io_oe_o[IO_PER_CH*c] && io_pin_o[IO_PER_CH*c])
        else $error("Ring relay pin not forced to drive");

      a_out_value: assert property (@(posedge clock_i) disable iff (reset_i) // see R3
        dir_ff[IO_PER_CH*c+1] |=> io_oe_o[IO_PER_CH*c+1] &&
          (io_pin_o[IO_PER_CH*c+1] == $past(io_wr_value_i[IO_PER_CH*c+1])))
        else $error("Output pin does not carry written value");

      a_sw_reset_scope: assert property (@(posedge clock_i) disable iff (reset_i) // see R20
        sw_reset_i[c] && !global_status_rd_i && !global_status_wr_i && !(|ev_set[EV_W*c +: EV_W])
          |=> (local_event_status_o[EV_W*c +: EV_W] == '0) &&
              ((global_irq_status_o & $past(global_irq_status_o)) == $past(global_irq_status_o)))
        else $error("Software reset scope wrong");
    end
  endgenerate

  assign any_irq = |chan_irq;

  // ****************************************************
  // Interrupt outputs
  // ****************************************************
  // Active level follows polarity; the unused path stays inactive
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      irq_o <= ~irq_polarity_i; // Inactive, see R19
      upstream_irq_first_o <= {2{~irq_polarity_i}};
      upstream_irq_second_o <= {2{~irq_polarity_i}};
    end
    else if (host_port_mode_i)
    begin
      irq_o <= any_irq ~^ irq_polarity_i; // see R14 R16 R22
      upstream_irq_first_o <= {2{~irq_polarity_i}};
      upstream_irq_second_o <= {2{~irq_polarity_i}};
    end
    else
    begin
      irq_o <= ~irq_polarity_i;
      upstream_irq_first_o <= {chan_irq[2], chan_irq[0]} ~^ {2{irq_polarity_i}}; // see R15 R16
      upstream_irq_second_o <= {chan_irq[3], chan_irq[1]} ~^ {2{irq_polarity_i}}; // see R15 R16
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  a_io_change_pend: assert property (@(posedge clock_i) disable iff (reset_i) // see R8
    io_set[2] |=> local_io_status_o[2])
    else $error("IO change did not set pending bit");

  a_rise_only: assert property (@(posedge clock_i) disable iff (reset_i) // see R13
    $rose(local_event_status_o[EV_W+EV_OVER_TEMPERATURE_FLAG]) |-> $past(ev_set[EV_W+EV_OVER_TEMPERATURE_FLAG]))
    else $error("Temperature pending without rising edge");

  a_read_clear: assert property (@(posedge clock_i) disable iff (reset_i) // see R17
    global_status_rd_i && !(|hook_set) && !(|gk_set) |=> global_irq_status_o == '0)
    else $error("Global read did not clear status");

  a_write_clear_all: assert property (@(posedge clock_i) disable iff (reset_i) // see R18
    global_status_wr_i && !(|io_set) && !(|ev_set) && !(|hook_set) && !(|gk_set)
      |=> (local_io_status_o == '0) && (local_event_status_o == '0) && (global_irq_status_o == '0))
    else $error("Clear-all write left status set");

  a_irq_active: assert property (@(posedge clock_i) disable iff (reset_i) // see R14
    host_port_mode_i && any_irq |=> irq_o == $past(irq_polarity_i))
    else $error("Interrupt pin not active with pending source");

  a_irq_release: assert property (@(posedge clock_i) disable iff (reset_i) // see R22
    host_port_mode_i && !any_irq |=> irq_o == !$past(irq_polarity_i))
    else $error("Interrupt pin stuck active");

  a_unmaskable_tone: assert property (@(posedge clock_i) disable iff (reset_i) // see R11
    local_event_status_o[EV_W*2+EV_TONE] && !host_port_mode_i |=> upstream_irq_first_o[1] == $past(irq_polarity_i))
    else $error("Tone done failed to interrupt");

  a_reset_idle: assert property (@(posedge clock_i) // see R19
    reset_i && irq_polarity_i |=> !irq_o && (global_irq_status_o == '0) && (local_event_status_o == '0))
    else $error("Reset left interrupt state active");

endmodule

// ### testbench/lidi_host_model.sv
// Host model issuing global status read and clear-all strobes.
// Assumes one-cycle requests from the bench on clock_i.
`timescale 1ns/1ps
module lidi_host_model (
  input wire logic clock_i, // System clock
  input wire logic reset_i, // Hardware reset
  input wire logic rd_req_i, // Ask for global read
  input wire logic wr_req_i, // Ask for clear-all write
  output logic rd_o, // Global read strobe
  output logic wr_o // Global write strobe
);
  logic clk_sel_ff; // Clock frequency chosen
  // Strobes only once the clock select step is done
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      clk_sel_ff <= 1'b0;
      rd_o <= 1'b0;
      wr_o <= 1'b0;
    end
    else
    begin
      clk_sel_ff <= 1'b1;
      rd_o <= rd_req_i & clk_sel_ff;
      wr_o <= wr_req_i & clk_sel_ff;
    end
  end
endmodule

// ### testbench/test_lidi_top.sv
// Self-checking bench for the IO debounce and interrupt block.
// Assumes TICK_LEN of 4 cycles and the host model for global strobes.
`timescale 1ns/1ps
module test_lidi_top;
  import lidi_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic mode = 1'b1, pol = 1'b1, rd_req = 1'b0, wr_req = 1'b0, g_rd, g_wr, irq;
  logic [3:0] swr = '0, ring = '0, hk = '0, gk = '0, gkp = '0, ot = '0, rmp = '0;
  logic [3:0] tn = '0, lm = '0, m = '0, iord = '0, evrd = '0;
  logic [15:0] dir = '0, wv = '0, per = '0, pin = '0, iom = '0, p_o, oe_o, v_o, ios_o;
  logic [7:0] gs_o;
  logic [19:0] ev_o;
  logic [1:0] up1, up2;
  int err_total = 0;
  int checked = 0;
  always #50 clock_i = ~clock_i;
  lidi_host_model host (.clock_i(clock_i), .reset_i(reset_i), .rd_req_i(rd_req), .wr_req_i(wr_req),
    .rd_o(g_rd), .wr_o(g_wr));
  lidi_top #(.TICK_LEN(4)) DUT (.clock_i(clock_i), .reset_i(reset_i), .sw_reset_i(swr),
    .host_port_mode_i(mode), .irq_polarity_i(pol), .io_dir_i(dir), .io_wr_value_i(wv),
    .io_debounce_period_i(per), .ext_ring_i(ring), .io_pin_i(pin), .io_pin_o(p_o), .io_oe_o(oe_o),
    .io_value_o(v_o), .hook_state_i(hk), .ground_key_state_i(gk), .ground_key_polarity_i(gkp),
    .over_temperature_flag_i(ot), .ramp_done_i(rmp), .tone_detect_done_flag_i(tn),
    .level_meter_done_flag_i(lm), .hook_mask_i(m), .ground_key_mask_i(m), .ground_key_polarity_mask_i(m),
    .over_temperature_mask_i(m), .ramp_mask_i(m), .io_mask_i(iom), .global_status_rd_i(g_rd),
    .global_status_wr_i(g_wr), .io_status_rd_i(iord), .event_status_rd_i(evrd),
    .global_irq_status_o(gs_o), .local_io_status_o(ios_o), .local_event_status_o(ev_o), .irq_o(irq),
    .upstream_irq_first_o(up1), .upstream_irq_second_o(up2));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Wait edges, then settle
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hook change, pin, global read clear
  task automatic t_hook();
    chk({gs_o, irq, oe_o}, 25'h0);
    @(posedge clock_i); hk[0] <= 1'b1; cyc(3);
    chk(gs_o, 8'h01);
    chk(irq, 1'b1);
    @(posedge clock_i); rd_req <= 1'b1;
    @(posedge clock_i); rd_req <= 1'b0; cyc(4);
    chk({gs_o, irq}, 9'h0);
  endtask
  // Output pins and forced ring relay pin
  task automatic t_pins();
    @(posedge clock_i); dir[1] <= 1'b1; wv[1] <= 1'b1; ring[0] <= 1'b1; cyc(3);
    chk(oe_o, 16'h0003);
    chk({p_o[1:0], v_o[1]}, 3'h7);
  endtask
  // Debounce hold at shortest period, short glitch rejected
  task automatic t_deb();
    @(posedge clock_i); pin[3:2] <= 2'h3; cyc(14);
    chk(v_o[3:2], 2'h0);
    @(posedge clock_i); pin[3] <= 1'b0; cyc(16);
    chk(v_o[3:2], 2'h1);
    chk(ios_o, 16'h0004);
  endtask
  // Rise-only events, serial flags, software reset, clear-all
  task automatic t_event();
    @(posedge clock_i); ot[1] <= 1'b1; hk[3] <= 1'b1; cyc(3);
    chk(ev_o[6], 1'b1);
    @(posedge clock_i); evrd[1] <= 1'b1;
    @(posedge clock_i); evrd[1] <= 1'b0; ot[1] <= 1'b0; cyc(3);
    chk(ev_o[6], 1'b0);
    @(posedge clock_i); mode <= 1'b0; pol <= 1'b0; m <= '1; iom <= '1;
    @(posedge clock_i); tn[2] <= 1'b1; cyc(4);
    chk({up1, up2}, 4'h7);
    @(posedge clock_i); swr[2] <= 1'b1;
    @(posedge clock_i); swr[2] <= 1'b0; cyc(3);
    chk({ev_o[13], gs_o[3], up1}, 4'h7);
    @(posedge clock_i); wr_req <= 1'b1;
    @(posedge clock_i); wr_req <= 1'b0; cyc(4);
    chk({gs_o, ios_o}, 24'h0);
  endtask
  // Ground-key, polarity both ways, ramp and level rises, local IO read clear
  task automatic t_gkey();
    @(posedge clock_i); gk[1] <= 1'b1; gkp[1] <= 1'b1; rmp[3] <= 1'b1; lm[0] <= 1'b1; pin[2] <= 1'b0; cyc(3);
    chk({gs_o[5], ev_o[5], ev_o[17], ev_o[4]}, 4'hf);
    chk({up1, up2, irq}, 5'h17);
    @(posedge clock_i); evrd[1] <= 1'b1;
    @(posedge clock_i); evrd[1] <= 1'b0; gkp[1] <= 1'b0; cyc(24);
    chk({ev_o[5], v_o[2], ios_o}, 18'h20004);
    @(posedge clock_i); iord[0] <= 1'b1;
    @(posedge clock_i); iord[0] <= 1'b0; cyc(2);
    chk(ios_o, 16'h0);
  endtask
  initial
  begin
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    cyc(2);
    t_hook();
    t_pins();
    t_deb();
    t_event();
    t_gkey();
    report_and_stop();
  end
  // Watchdog
  initial
  begin
    #1000000;
    err_total++;
    report_and_stop();
  end
endmodule
